// ==== verilog/rnab_defines.svh ====
// Constants of the node address and line rate block: timing, offsets, fields, resets.
`ifndef RNAB_DEFINES_SVH
`define RNAB_DEFINES_SVH

`define RNAB_CLK_HZ        200000000
`define RNAB_CLK_NS        5
`define RNAB_US_NS         1000
`define RNAB_US_CYC        (`RNAB_US_NS / `RNAB_CLK_NS)
`define RNAB_OVS           16

`define RNAB_DIV_9600      (`RNAB_CLK_HZ / (`RNAB_OVS * 9600))
`define RNAB_DIV_19200     (`RNAB_CLK_HZ / (`RNAB_OVS * 19200))
`define RNAB_DIV_38400     (`RNAB_CLK_HZ / (`RNAB_OVS * 38400))
`define RNAB_DIV_57600     (`RNAB_CLK_HZ / (`RNAB_OVS * 57600))
`define RNAB_DIV_115200    (`RNAB_CLK_HZ / (`RNAB_OVS * 115200))
`define RNAB_RATE_LAST     4'h4

`define RNAB_OFF_CTRL      8'h00
`define RNAB_OFF_TXDLY     8'h04
`define RNAB_OFF_STATUS    8'h08
`define RNAB_OFF_ADDR      8'h0c
`define RNAB_OFF_CMD       8'h10
`define RNAB_OFF_TXDATA    8'h14

`define RNAB_CTRL_UPPER    0
`define RNAB_CTRL_FOUR     1
`define RNAB_ST_NODE_LSB   0
`define RNAB_ST_RATE_LSB   4
`define RNAB_ST_RSVD       8
`define RNAB_ST_PEND       9
`define RNAB_ST_BUSY       10
`define RNAB_ST_FULL       11

`define RNAB_CTRL_RST      2'h0
`define RNAB_TXDLY_RST     16'h0064

`define RNAB_LOWER_BASE    8'h30
`define RNAB_UPPER_BASE    8'h20
`define RNAB_UPPER_ZERO    8'h40
`define RNAB_CR            8'h0d

`endif

// ==== verilog/rnab_pkg.sv ====
// Types shared by the node address and line rate block.
package rnab_pkg;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } rnab_rx_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_SEND = 2'h2
    } rnab_tx_e;

    typedef struct packed {
        logic four_wire;
        logic upper_bank;
    } rnab_ctrl_s;

    typedef struct packed {
        logic [3:0] rate_pos;
        logic [3:0] node_pos;
    } rnab_sw_s;

endpackage

// ==== verilog/rnab_baud_gen.sv ====
// Oversampling tick divider for the serial line.
`timescale 1ns/100ps
module rnab_baud_gen #(
    parameter int DIV_W = 11
) (
    // Clock and reset.
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Divisor and tick.
    input  wire logic [DIV_W-1:0] div,
    output logic                  tick
);

    logic [DIV_W-1:0] cnt_r;
    wire              wrap = (cnt_r >= div - DIV_W'(1));

    if (DIV_W < 11)
    begin : g_chk
        $error("Divisor width too small for the slowest line rate.");
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            cnt_r <= wrap ? '0 : cnt_r + DIV_W'(1);
            tick  <= wrap;
        end
    end

endmodule

// ==== verilog/rnab_node.sv ====
// Serial command port with switch-set node address and line rate, and a reply delay set by software.
// Notes on behaviour
// - The address switch picks node 0 to 15, giving characters '0' to '9' and ':' to '?'.
// - With the upper bank selected, position 0 gives '@' and positions 1 to F give '!' to '/'.
// - The rate switch gives 9600, 19200, 38400, 57600 or 115200 bps; 5 to 9 are reserved.
// - The node waits a programmable transmit delay before driving its reply.
// - In four-wire mode the node listens on one pair and replies on the other.
//
// Added by the designer: the address map and the APB register port.
`include "rnab_defines.svh"
`timescale 1ns/100ps
module rnab_node #(
    parameter int ADDR_W = 8,
    parameter int DIV_W  = 11
) (
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Rotary switches.
    input  wire logic [3:0]        node_address_switch,
    input  wire logic [3:0]        line_rate_switch,
    // Serial line.
    input  wire logic              rxd,
    output logic                   txd,
    output logic                   tx_drive_en
);

    if (ADDR_W < 8)
    begin : g_chk
        $error("Address width cannot hold the register map.");
    end

    // Pin synchronisers; the first stages feed only the second stages.
    logic [8:0] pin_s1_r;
    logic [8:0] pin_s2_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_r <= 9'h1ff;
            pin_s2_r <= 9'h1ff;
        end
        else
        begin
            pin_s1_r <= {rxd, line_rate_switch, node_address_switch};
            pin_s2_r <= pin_s1_r;
        end
    end
    rnab_pkg::rnab_sw_s sw;
    assign sw = rnab_pkg::rnab_sw_s'(pin_s2_r[7:0]);

    // Registers written by software.
    rnab_pkg::rnab_ctrl_s ctrl_r;
    logic [15:0]          txdly_r;

    // Address character from the switch and bank.
    wire [7:0] lower_char = `RNAB_LOWER_BASE + {4'h0, sw.node_pos};
    wire [7:0] upper_char = (sw.node_pos == 4'h0) ? `RNAB_UPPER_ZERO
                          : `RNAB_UPPER_BASE + {4'h0, sw.node_pos};
    wire [7:0] addr_char  = ctrl_r.upper_bank ? upper_char : lower_char;
    wire [4:0] node_num   = {ctrl_r.upper_bank, sw.node_pos};

    // Line rate; a reserved position falls back to the slowest rate.
    wire             rate_rsvd = sw.rate_pos > `RNAB_RATE_LAST;
    wire [DIV_W-1:0] baud_div  =
        (sw.rate_pos == 4'h1) ? DIV_W'(`RNAB_DIV_19200) :
        (sw.rate_pos == 4'h2) ? DIV_W'(`RNAB_DIV_38400) :
        (sw.rate_pos == 4'h3) ? DIV_W'(`RNAB_DIV_57600) :
        (sw.rate_pos == 4'h4) ? DIV_W'(`RNAB_DIV_115200) : DIV_W'(`RNAB_DIV_9600);
    logic tick;
    rnab_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .div     (baud_div),
        .tick    (tick)
    );

    // In two-wire mode the node's own reply is not heard back as a command.
    rnab_pkg::rnab_tx_e tx_st_r;
    wire rx_line = (ctrl_r.four_wire || tx_st_r != rnab_pkg::TX_SEND) ? pin_s2_r[8]
                 : 1'b1;

    // Receiver.
    rnab_pkg::rnab_rx_e rx_st_r;
    logic [3:0]         rx_tc_r;
    logic [2:0]         rx_bc_r;
    logic [7:0]         rx_sh_r;
    logic               rx_vld_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_r  <= rnab_pkg::RX_IDLE;
            rx_tc_r  <= 4'h0;
            rx_bc_r  <= 3'h0;
            rx_sh_r  <= 8'h00;
            rx_vld_r <= 1'b0;
        end
        else
        begin
            rx_vld_r <= 1'b0;
            unique case (rx_st_r)
                rnab_pkg::RX_IDLE:
                    if (!rx_line)
                    begin
                        rx_st_r <= rnab_pkg::RX_START;
                        rx_tc_r <= 4'h0;
                    end
                rnab_pkg::RX_START:
                    if (tick)
                    begin
                        rx_tc_r <= rx_tc_r + 4'h1;
                        if (rx_tc_r == 4'h7)
                        begin
                            rx_st_r <= rx_line ? rnab_pkg::RX_IDLE : rnab_pkg::RX_DATA;
                            rx_tc_r <= 4'h0;
                            rx_bc_r <= 3'h0;
                        end
                    end
                rnab_pkg::RX_DATA:
                    if (tick)
                    begin
                        rx_tc_r <= rx_tc_r + 4'h1;
                        if (rx_tc_r == 4'hf)
                        begin
                            rx_sh_r <= {rx_line, rx_sh_r[7:1]};
                            rx_bc_r <= rx_bc_r + 3'h1;
                            if (rx_bc_r == 3'h7)
                                rx_st_r <= rnab_pkg::RX_STOP;
                        end
                    end
                rnab_pkg::RX_STOP:
                    if (tick)
                    begin
                        rx_tc_r <= rx_tc_r + 4'h1;
                        if (rx_tc_r == 4'hf)
                        begin
                            rx_st_r  <= rnab_pkg::RX_IDLE;
                            rx_vld_r <= rx_line;
                        end
                    end
            endcase
        end
    end

    // Command framing: address character, body, carriage return.
    logic       first_r;
    logic       match_r;
    logic       got_cmd_r;
    logic [7:0] cmd_r;
    logic       cmd_done_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_r    <= 1'b1;
            match_r    <= 1'b0;
            got_cmd_r  <= 1'b0;
            cmd_r      <= 8'h00;
            cmd_done_r <= 1'b0;
        end
        else
        begin
            cmd_done_r <= 1'b0;
            if (rx_vld_r && first_r)
            begin
                match_r   <= (rx_sh_r == addr_char);
                first_r   <= (rx_sh_r == `RNAB_CR);
                got_cmd_r <= 1'b0;
            end
            else if (rx_vld_r && rx_sh_r == `RNAB_CR)
            begin
                first_r    <= 1'b1;
                match_r    <= 1'b0;
                cmd_done_r <= match_r;
            end
            else if (rx_vld_r && match_r && !got_cmd_r)
            begin
                cmd_r     <= rx_sh_r;
                got_cmd_r <= 1'b1;
            end
        end
    end

    // Reply delay in microseconds, started at the end of our own command.
    logic [7:0]  us_cnt_r;
    logic [15:0] dly_r;
    wire         us_tick = (us_cnt_r == 8'(`RNAB_US_CYC - 1));
    wire         dly_zero = (dly_r == 16'h0000);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            us_cnt_r <= 8'h00;
            dly_r    <= 16'h0000;
        end
        else
        begin
            us_cnt_r <= us_tick ? 8'h00 : us_cnt_r + 8'h01;
            if (cmd_done_r)
                dly_r <= txdly_r;
            else if (us_tick && !dly_zero)
                dly_r <= dly_r - 16'h0001;
        end
    end

    // Transmitter; it drives only for a pending reply once the delay has run out.
    logic       pend_r;
    logic       hold_full_r;
    logic [7:0] hold_r;
    logic [9:0] tx_sh_r;
    logic [3:0] tx_tc_r;
    logic [3:0] tx_bc_r;
    logic       last_cr_r;
    wire        tx_start = (tx_st_r == rnab_pkg::TX_IDLE) && hold_full_r && pend_r && dly_zero;
    wire        tx_end   = (tx_st_r == rnab_pkg::TX_SEND) && tick && tx_tc_r == 4'hf
                        && tx_bc_r == 4'h9;
    wire        acc      = psel && penable;
    wire        wr_txd   = acc && pwrite && paddr[7:0] == `RNAB_OFF_TXDATA;
    wire        hold_ld  = wr_txd && pend_r && !hold_full_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st_r     <= rnab_pkg::TX_IDLE;
            tx_sh_r     <= 10'h3ff;
            tx_tc_r     <= 4'h0;
            tx_bc_r     <= 4'h0;
            last_cr_r   <= 1'b0;
            hold_r      <= 8'h00;
            hold_full_r <= 1'b0;
            pend_r      <= 1'b0;
        end
        else
        begin
            // A new command that lands as the last reply ends keeps the node pending.
            pend_r <= cmd_done_r || (pend_r && !(tx_end && last_cr_r));
            if (hold_ld)
            begin
                hold_r      <= pwdata[7:0];
                hold_full_r <= 1'b1;
            end
            if (tx_start)
            begin
                tx_st_r     <= rnab_pkg::TX_SEND;
                tx_sh_r     <= {1'b1, hold_r, 1'b0};
                tx_tc_r     <= 4'h0;
                tx_bc_r     <= 4'h0;
                last_cr_r   <= (hold_r == `RNAB_CR);
                hold_full_r <= 1'b0;
            end
            else if (tx_st_r == rnab_pkg::TX_SEND && tick)
            begin
                tx_tc_r <= tx_tc_r + 4'h1;
                if (tx_tc_r == 4'hf)
                begin
                    tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                    tx_bc_r <= tx_bc_r + 4'h1;
                    if (tx_end)
                        tx_st_r <= rnab_pkg::TX_IDLE;
                end
            end
        end
    end
    assign txd         = tx_sh_r[0];
    assign tx_drive_en = tx_st_r[1];

    // APB slave: zero wait states, read data latched in the setup cycle.
    wire [7:0] off    = paddr[7:0];
    wire       mapped = (off == `RNAB_OFF_CTRL) || (off == `RNAB_OFF_TXDLY)
                     || (off == `RNAB_OFF_STATUS) || (off == `RNAB_OFF_ADDR)
                     || (off == `RNAB_OFF_CMD) || (off == `RNAB_OFF_TXDATA);
    wire [31:0] status = {20'h00000, hold_full_r, tx_drive_en, pend_r, rate_rsvd,
                          sw.rate_pos, sw.node_pos};
    wire [31:0] rmux   = (off == `RNAB_OFF_CTRL)   ? {30'h0, ctrl_r} :
                         (off == `RNAB_OFF_TXDLY)  ? {16'h0000, txdly_r} :
                         (off == `RNAB_OFF_STATUS) ? status :
                         (off == `RNAB_OFF_ADDR)   ? {19'h00000, node_num, addr_char} :
                         (off == `RNAB_OFF_CMD)    ? {24'h000000, cmd_r} : 32'h00000000;
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h00000000;
            ctrl_r  <= rnab_pkg::rnab_ctrl_s'(`RNAB_CTRL_RST);
            txdly_r <= `RNAB_TXDLY_RST;
        end
        else
        begin
            if (psel && !penable && !pwrite)
                prdata <= rmux;
            if (acc && pwrite && off == `RNAB_OFF_CTRL)
                ctrl_r <= rnab_pkg::rnab_ctrl_s'(pwdata[1:0]);
            if (acc && pwrite && off == `RNAB_OFF_TXDLY)
                txdly_r <= pwdata[15:0];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    lower_bank_map_a: assert property (!ctrl_r.upper_bank |->
        addr_char == 8'h30 + {4'h0, pin_s2_r[3:0]})
        else $error("Lower bank address character wrong.");
    upper_bank_map_a: assert property (ctrl_r.upper_bank && pin_s2_r[3:0] != 4'h0 |->
        addr_char == 8'h20 + {4'h0, pin_s2_r[3:0]} && node_num >= 5'h10)
        else $error("Upper bank address character wrong.");
    fast_rate_div_a: assert property (pin_s2_r[7:4] == 4'h4 |->
        baud_div == DIV_W'(108))
        else $error("Divisor for the fastest rate wrong.");
    delay_load_a: assert property (cmd_done_r |=> dly_r == $past(txdly_r) && pend_r)
        else $error("Reply delay not loaded at end of command.");
    start_after_delay_a: assert property ($rose(tx_drive_en) |->
        $past(dly_zero) && $past(pend_r))
        else $error("Reply started before the delay ran out.");
    driver_owner_a: assert property (tx_drive_en |-> pend_r)
        else $error("Driver enabled without a pending command.");
    line_idle_a: assert property (!tx_drive_en |-> txd)
        else $error("Line not idle while driver is off.");
    own_echo_a: assert property (tx_drive_en && !ctrl_r.four_wire |=>
        rx_st_r == rnab_pkg::RX_IDLE || $past(rx_st_r) != rnab_pkg::RX_IDLE)
        else $error("Own reply heard as a command on a two-wire line.");

endmodule

// ==== verif/rnab_host_model.sv ====
// Host controller on the serial pair: sends command frames and samples replies.
`timescale 1ns/100ps
module rnab_host_model #(
    parameter int BIT = 1728
) (
    // Clock.
    input  wire logic pclk,
    // Serial line towards and from the node.
    input  wire logic txd,
    input  wire logic tx_drive_en,
    input  wire logic four_wire,
    output logic      rxd
);
    logic host_bit = 1'b1;
    logic host_en  = 1'b0;
    int   cyc      = 0;
    int   end_cyc  = 0;
    int   drives   = 0;

    // The two-wire pair is shared, so the node also hears its own reply; bias holds it high.
    assign rxd = host_en ? host_bit : ((!four_wire && tx_drive_en) ? txd : 1'b1);

    always @(posedge pclk)
        cyc <= cyc + 1;

    always @(posedge tx_drive_en)
        drives++;

    task send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge pclk);
        host_en <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            host_bit <= f[i];
            repeat (BIT) @(posedge pclk);
        end
        host_en  <= 1'b0;
        end_cyc = cyc;
    endtask

    // Waits for the node's driver, then samples start, data and stop at bit centres.
    task recv(output logic [9:0] f, output int lat);
        int n;
        n = 0;
        while (tx_drive_en !== 1'b1 && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        lat = cyc - end_cyc;
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 10; i++)
        begin
            f[i] = txd;
            repeat (BIT) @(posedge pclk);
        end
    endtask
endmodule

// ==== verif/rnab_node_tb.sv ====
// Testbench of the node: register access, switch decoding and two command round trips.
`include "rnab_defines.svh"
`timescale 1ns/100ps
module rnab_node_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  node_sw = 4'h0;
    logic [3:0]  rate_sw = 4'h0;
    logic        rxd;
    logic        txd;
    logic        tx_drive_en;
    logic        four_w = 1'b0;
    logic [31:0] rdat;
    logic        rerr;
    logic [9:0]  frame;
    logic [7:0]  ch;
    int          lat;
    int          errors = 0;
    int          n_checks = 0;

    always #2.5 pclk = ~pclk;

    rnab_node rnab_node_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .node_address_switch(node_sw), .line_rate_switch(rate_sw),
        .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en)
    );

    rnab_host_model #(.BIT(`RNAB_OVS * `RNAB_DIV_115200)) rnab_host_model_inst (
        .pclk(pclk), .txd(txd), .tx_drive_en(tx_drive_en), .four_wire(four_w), .rxd(rxd)
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 16)
            errors++;
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task report_and_stop;
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (160000) @(posedge pclk);
        errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(txd, 1'b1);
        chk(tx_drive_en, 1'b0);
        apb(1'b0, `RNAB_OFF_CTRL, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, `RNAB_OFF_TXDLY, 32'h0);
        chk(rdat, 32'h0064);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        // Both banks, every switch position: character and node number.
        for (int bank = 0; bank < 2; bank++)
        begin
            apb(1'b1, `RNAB_OFF_CTRL, bank);
            for (int p = 0; p < 16; p++)
            begin
                node_sw <= p[3:0];
                repeat (4) @(posedge pclk);
                ch = bank ? ((p == 0) ? 8'h40 : 8'h20 + p[7:0]) : 8'h30 + p[7:0];
                apb(1'b0, `RNAB_OFF_ADDR, 32'h0);
                chk(rdat, {19'h0, bank[0], p[3:0], ch});
                apb(1'b0, `RNAB_OFF_STATUS, 32'h0);
                chk(rdat[3:0], p[3:0]);
            end
        end
        for (int r = 0; r < 10; r++)
        begin
            rate_sw <= r[3:0];
            repeat (4) @(posedge pclk);
            apb(1'b0, `RNAB_OFF_STATUS, 32'h0);
            chk(rdat[8:4], {(r > 4), r[3:0]});
        end
        // Upper bank, two-wire, node 5, 115200 bps, 20 us reply delay.
        node_sw <= 4'h5;
        rate_sw <= 4'h4;
        apb(1'b1, `RNAB_OFF_CTRL, 32'h1);
        apb(1'b1, `RNAB_OFF_TXDLY, 32'd20);
        apb(1'b0, `RNAB_OFF_TXDLY, 32'h0);
        chk(rdat, 32'd20);
        apb(1'b1, `RNAB_OFF_STATUS, 32'hffffffff);
        // A reply byte with nothing pending is refused.
        apb(1'b1, `RNAB_OFF_TXDATA, 32'h41);
        rnab_host_model_inst.send(8'h25);
        rnab_host_model_inst.send(8'h58);
        rnab_host_model_inst.send(`RNAB_CR);
        apb(1'b0, `RNAB_OFF_STATUS, 32'h0);
        chk(rdat[11:9], 3'h1);
        chk(rnab_host_model_inst.drives, 0);
        apb(1'b0, `RNAB_OFF_CMD, 32'h0);
        chk(rdat, 32'h58);
        apb(1'b1, `RNAB_OFF_TXDATA, {24'h0, `RNAB_CR});
        rnab_host_model_inst.recv(frame, lat);
        chk(frame, {1'b1, `RNAB_CR, 1'b0});
        // Delay starts at the stop-bit centre, half a bit before the host's frame end.
        chk(lat >= 2900 && lat <= 3300, 1'b1);
        chk(rnab_host_model_inst.drives, 1);
        apb(1'b0, `RNAB_OFF_STATUS, 32'h0);
        chk(rdat[10:9], 2'h0);
        chk(tx_drive_en, 1'b0);
        // Four-wire with a 1 us delay; separate pairs let the host talk during the reply.
        apb(1'b1, `RNAB_OFF_CTRL, 32'h3);
        apb(1'b1, `RNAB_OFF_TXDLY, 32'd1);
        rnab_host_model_inst.send(8'h25);
        rnab_host_model_inst.send(`RNAB_CR);
        apb(1'b1, `RNAB_OFF_TXDATA, {24'h0, `RNAB_CR});
        // The lower-bank character of the same position belongs to another node.
        fork
            rnab_host_model_inst.recv(frame, lat);
            begin
                rnab_host_model_inst.send(8'h35);
                rnab_host_model_inst.send(`RNAB_CR);
            end
        join
        chk(frame, {1'b1, `RNAB_CR, 1'b0});
        chk(lat <= 40, 1'b1);
        chk(rnab_host_model_inst.drives, 2);
        apb(1'b0, `RNAB_OFF_STATUS, 32'h0);
        chk(rdat[11:9], 3'h0);
        report_and_stop();
    end
endmodule
